// *** core/agp_pkg.sv ***
// constants, types and field layouts for the analog gain and power register bank
package agp_pkg;

	// ************************************************************
	// register addresses on the serial control port
	// ************************************************************
	localparam logic [7:0] ADDR_GENERAL_RESET         = 8'h01;
	localparam logic [7:0] ADDR_VOLUME_SIDETONE_LEVEL = 8'h62;
	localparam logic [7:0] ADDR_MIC_INPUT_GAIN        = 8'h63;
	localparam logic [7:0] ADDR_ANALOG_POWER_FIRST    = 8'h64;
	localparam logic [7:0] ADDR_ANALOG_POWER_SECOND   = 8'h65;
	localparam logic [7:0] ADDR_CODEC_OPERATING_MODE  = 8'h70;

	// ************************************************************
	// reset values and field positions
	// ************************************************************
	localparam logic [7:0] REG_RESET_VALUE   = 8'h00;
	localparam int         VOLUME_LSB        = 3;
	localparam int         SIDETONE_LVL_LSB  = 1;
	localparam int         SIDETONE_EN_BIT   = 0;
	localparam int         MIC_GAIN_LSB      = 3;
	localparam int         ALIAS_PWR_LSB     = 6;
	localparam int         IMAGE_PWR_LSB     = 4;
	localparam int         ENC_PWR_LSB       = 2;
	localparam int         DEC_PWR_LSB       = 0;
	localparam int         MIC_AMP_PWR_LSB   = 6;
	localparam int         GAIN_AMP_PWR_LSB  = 4;
	localparam int         VOL_AMP_PWR_LSB   = 2;
	localparam int         CRYSTAL_SAVE_BIT  = 1;
	localparam int         ANALOG_EN_BIT     = 0;
	localparam int         MODE_LSB          = 0;

	// ************************************************************
	// codes
	// ************************************************************
	localparam logic [4:0] GAIN_CODE_OFF     = 5'h00;
	localparam logic [1:0] PWR_DOWN          = 2'h0;
	localparam logic [1:0] PWR_LOWEST        = 2'h1;
	localparam logic [1:0] PWR_LOW           = 2'h2;
	localparam logic [1:0] PWR_NORMAL        = 2'h3;

	// sidetone gain selection: 0, -9, -15, -21 dB
	typedef enum logic [1:0] {
		ST_0DB   = 2'h0,
		ST_M9DB  = 2'h1,
		ST_M15DB = 2'h2,
		ST_M21DB = 2'h3
	} sidetone_gain_e;

	// one register write from the serial control port
	typedef struct packed {
		logic       valid;
		logic [7:0] addr;
		logic [7:0] data;
	} reg_write_s;

	// effective gain settings for the analog path
	typedef struct packed {
		logic [4:0]     volume_code;
		logic           volume_mute;
		sidetone_gain_e sidetone_gain;
		logic           sidetone_on;
		logic [4:0]     mic_gain_code;
		logic           mic_gain_off;
	} gain_ctrl_s;

	// effective power codes for each analog block
	typedef struct packed {
		logic [1:0] anti_alias_filter;
		logic [1:0] anti_image_filter;
		logic [1:0] encode_converter;
		logic [1:0] decode_converter;
		logic [1:0] mic_amp;
		logic [1:0] gain_amp;
		logic [1:0] volume_amp;
		logic       bandgap_on;
		logic       crystal_oscillator_pd;
	} power_ctrl_s;

endpackage

// *** core/agp_wo_reg.sv ***
// one write-only control register cleared by general reset
`timescale 1ns/1ps
`default_nettype none
module agp_wo_reg
	import agp_pkg::*;
#(
	parameter int             WIDTH     = 8,
	parameter logic [7:0]     ADDR      = 8'h00,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// clock and reset
	input  wire  logic             clk_sys,
	input  wire  logic             resetn,
	// write port
	input  wire  reg_write_s       wr,
	input  wire  logic             clear,
	// stored value
	output logic [WIDTH-1:0]       value_reg
);
	initial begin
		if (WIDTH < 1 || WIDTH > 8) begin
			$error("agp_wo_reg width out of range");
		end
	end

	wire logic hit = wr.valid && (wr.addr == ADDR);
	logic [WIDTH-1:0] value_next;
	assign value_next = clear ? RST_VAL : (hit ? wr.data[WIDTH-1:0] : value_reg);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			value_reg <= RST_VAL;
		end else begin
			value_reg <= value_next;
		end
	end
endmodule
`default_nettype wire

// *** core/audio_gain_power_regs.sv ***
// write-only gain, sidetone and analog power register bank
//
// Functional notes
// RQ1: volume field zero mutes; codes 1..31 give -33 to +12 dB in 1.5 dB.
// RQ2: sidetone level bits 2-1 select 0, -9, -15 or -21 dB.
// RQ3: sidetone enable one turns sidetone path on, zero turns it off.
// RQ4: mic gain field zero switches amp off; 1..31 give -7.5 to +7.5 dB.
// RQ5: host writes zeros to reserved gain and mode bits.
// RQ6: anti-alias filter power bits 7-6 select four levels, 00 off.
// RQ7: host keeps filter power on while the matching bypass is set.
// RQ8: anti-image filter power bits 5-4 also power sidetone amp, 00 off.
// RQ9: encode converter power bits 3-2 select four levels, 00 off.
// RQ10: decode converter power bits 1-0 select four levels, 00 off.
// RQ11: mic amplifier power bits 7-6 of second register, four levels.
// RQ12: input gain amplifier power bits 5-4, four levels, 00 off.
// RQ13: volume amplifier power bits 3-2, four levels, 00 off.
// RQ14: bit 1 of second power register powers down crystal oscillator.
// RQ15: master enable zero forces all analog power and bandgap off.
// RQ16: general reset command clears every write-only register to zero.
// RQ17: fields change only on own write; power codes gated by master enable.
`timescale 1ns/1ps
`default_nettype none
module audio_gain_power_regs
	import agp_pkg::*;
#(
	parameter int MODE_BITS = 3
) (
	// clock and reset
	input  wire  logic        clk_sys,
	input  wire  logic        resetn,
	// decoded serial control port write
	input  wire  logic        wr_valid,
	input  wire  logic [7:0]  wr_addr,
	input  wire  logic [7:0]  wr_data,
	// effective settings to the analog circuits
	output var gain_ctrl_s    gain_ctrl,
	output var power_ctrl_s   power_ctrl,
	output logic [MODE_BITS-1:0] codec_mode,
	output logic              reserved_written
);
	initial begin
		if (MODE_BITS < 1 || MODE_BITS > 3) begin
			$error("MODE_BITS out of range");
		end
	end

	// ************************************************************
	// write decode
	// ************************************************************
	reg_write_s wr;
	assign wr = '{valid: wr_valid, addr: wr_addr, data: wr_data};

	wire logic general_reset = wr_valid && (wr_addr == ADDR_GENERAL_RESET); // [RQ16]

	logic [7:0] vol_st_reg;
	logic [7:0] mic_gain_reg;
	logic [7:0] pwr1_reg;
	logic [7:0] pwr2_reg;
	logic [7:0] mode_reg;

	// each register loads only on its own address [RQ17] and clears on reset [RQ16]
	agp_wo_reg #(.WIDTH(8), .ADDR(ADDR_VOLUME_SIDETONE_LEVEL), .RST_VAL(REG_RESET_VALUE))
	u_vol_st (.clk_sys(clk_sys), .resetn(resetn), .wr(wr), .clear(general_reset),
		.value_reg(vol_st_reg));
	agp_wo_reg #(.WIDTH(8), .ADDR(ADDR_MIC_INPUT_GAIN), .RST_VAL(REG_RESET_VALUE))
	u_mic_gain (.clk_sys(clk_sys), .resetn(resetn), .wr(wr), .clear(general_reset),
		.value_reg(mic_gain_reg));
	agp_wo_reg #(.WIDTH(8), .ADDR(ADDR_ANALOG_POWER_FIRST), .RST_VAL(REG_RESET_VALUE))
	u_pwr1 (.clk_sys(clk_sys), .resetn(resetn), .wr(wr), .clear(general_reset),
		.value_reg(pwr1_reg));
	agp_wo_reg #(.WIDTH(8), .ADDR(ADDR_ANALOG_POWER_SECOND), .RST_VAL(REG_RESET_VALUE))
	u_pwr2 (.clk_sys(clk_sys), .resetn(resetn), .wr(wr), .clear(general_reset),
		.value_reg(pwr2_reg));
	agp_wo_reg #(.WIDTH(8), .ADDR(ADDR_CODEC_OPERATING_MODE), .RST_VAL(REG_RESET_VALUE))
	u_mode (.clk_sys(clk_sys), .resetn(resetn), .wr(wr), .clear(general_reset),
		.value_reg(mode_reg));

	// ************************************************************
	// gain decode
	// ************************************************************
	wire logic [4:0] volume_field = vol_st_reg[VOLUME_LSB +: 5];
	wire logic [1:0] st_lvl_field = vol_st_reg[SIDETONE_LVL_LSB +: 2];
	wire logic       st_en_field  = vol_st_reg[SIDETONE_EN_BIT];
	wire logic [4:0] mic_field    = mic_gain_reg[MIC_GAIN_LSB +: 5];

	assign gain_ctrl.volume_code   = volume_field;                       // [RQ1]
	assign gain_ctrl.volume_mute   = (volume_field == GAIN_CODE_OFF);    // [RQ1]
	assign gain_ctrl.sidetone_gain = sidetone_gain_e'(st_lvl_field);     // [RQ2]
	// sidetone amp shares the anti-image filter power
	assign gain_ctrl.sidetone_on   = st_en_field && power_ctrl.anti_image_filter != PWR_DOWN; // [RQ3]
	assign gain_ctrl.mic_gain_code = mic_field;                          // [RQ4]
	assign gain_ctrl.mic_gain_off  = (mic_field == GAIN_CODE_OFF);       // [RQ4]

	// ************************************************************
	// power decode, gated by master analog enable except crystal power-down
	// ************************************************************
	wire logic analog_en = pwr2_reg[ANALOG_EN_BIT];
	wire logic [1:0] gate = {2{analog_en}}; // [RQ15]

	assign power_ctrl.anti_alias_filter = pwr1_reg[ALIAS_PWR_LSB +: 2] & gate;    // [RQ6] [RQ17]
	assign power_ctrl.anti_image_filter = pwr1_reg[IMAGE_PWR_LSB +: 2] & gate;    // [RQ8]
	assign power_ctrl.encode_converter  = pwr1_reg[ENC_PWR_LSB +: 2] & gate;      // [RQ9]
	assign power_ctrl.decode_converter  = pwr1_reg[DEC_PWR_LSB +: 2] & gate;      // [RQ10]
	assign power_ctrl.mic_amp           = pwr2_reg[MIC_AMP_PWR_LSB +: 2] & gate;  // [RQ11]
	assign power_ctrl.gain_amp          = pwr2_reg[GAIN_AMP_PWR_LSB +: 2] & gate; // [RQ12]
	assign power_ctrl.volume_amp        = pwr2_reg[VOL_AMP_PWR_LSB +: 2] & gate;  // [RQ13]
	assign power_ctrl.bandgap_on        = analog_en;                             // [RQ15]
	assign power_ctrl.crystal_oscillator_pd = pwr2_reg[CRYSTAL_SAVE_BIT];        // [RQ14]

	// ************************************************************
	// mode and reserved-bit observation
	// ************************************************************
	assign codec_mode = mode_reg[MODE_LSB +: MODE_BITS];
	// flags host misuse of reserved bits, for debug only
	assign reserved_written = (mic_gain_reg[2:0] != 3'h0) || (mode_reg[7:3] != 5'h00); // [RQ5]

	// ************************************************************
	// checks
	// ************************************************************
	a_reset_clears: assert property (@(posedge clk_sys) disable iff (!resetn)
		general_reset |=> (vol_st_reg == 8'h00 && pwr2_reg == 8'h00)) // [RQ16]
		else $error("general reset did not clear registers");
	a_master_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
		!analog_en |-> (power_ctrl.anti_alias_filter == 2'h0 && power_ctrl.volume_amp == 2'h0
		&& !power_ctrl.bandgap_on)) // [RQ15]
		else $error("analog power not forced off");
	a_volume_load: assert property (@(posedge clk_sys) disable iff (!resetn)
		(wr_valid && wr_addr == ADDR_VOLUME_SIDETONE_LEVEL)
		|=> gain_ctrl.volume_code == $past(wr_data[7:3])) // [RQ1]
		else $error("volume field not loaded");
	a_mute_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
		gain_ctrl.volume_mute == (gain_ctrl.volume_code == 5'h00)) // [RQ1]
		else $error("mute does not match zero volume");
	a_field_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
		!(wr_valid && (wr_addr == ADDR_ANALOG_POWER_FIRST || wr_addr == ADDR_GENERAL_RESET))
		|=> $stable(pwr1_reg)) // [RQ17]
		else $error("power register changed without write");
	a_crystal_save: assert property (@(posedge clk_sys) disable iff (!resetn)
		(wr_valid && wr_addr == ADDR_ANALOG_POWER_SECOND)
		|=> power_ctrl.crystal_oscillator_pd == $past(wr_data[1])) // [RQ14]
		else $error("crystal power-save bit wrong");
	a_sidetone_off: assert property (@(posedge clk_sys) disable iff (!resetn)
		!vol_st_reg[0] |-> !gain_ctrl.sidetone_on) // [RQ3]
		else $error("sidetone on while disabled");
	a_mic_gain_off: assert property (@(posedge clk_sys) disable iff (!resetn)
		(wr_valid && wr_addr == ADDR_MIC_INPUT_GAIN && wr_data[7:3] == 5'h00)
		|=> gain_ctrl.mic_gain_off) // [RQ4]
		else $error("mic gain not off at code zero");
	a_aif_power: assert property (@(posedge clk_sys) disable iff (!resetn)
		analog_en |-> power_ctrl.anti_image_filter == pwr1_reg[5:4]) // [RQ8]
		else $error("anti-image power code wrong");
	a_st_level: assert property (@(posedge clk_sys) disable iff (!resetn)
		(wr_valid && wr_addr == ADDR_VOLUME_SIDETONE_LEVEL)
		|=> gain_ctrl.sidetone_gain == sidetone_gain_e'($past(wr_data[2:1]))) // [RQ2]
		else $error("sidetone level wrong");

	// ************************************************************
	// write strobes for the checks below
	// ************************************************************
	wire logic wr_vol   = wr_valid && (wr_addr == ADDR_VOLUME_SIDETONE_LEVEL);
	wire logic wr_mic   = wr_valid && (wr_addr == ADDR_MIC_INPUT_GAIN);
	wire logic wr_pwr1  = wr_valid && (wr_addr == ADDR_ANALOG_POWER_FIRST);
	wire logic wr_pwr2  = wr_valid && (wr_addr == ADDR_ANALOG_POWER_SECOND);
	wire logic wr_mode  = wr_valid && (wr_addr == ADDR_CODEC_OPERATING_MODE);
	wire logic wr_known = wr_vol || wr_mic || wr_pwr1 || wr_pwr2 || wr_mode || general_reset;

	// ************************************************************
	// power field checks
	// ************************************************************
	a_alias_power: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ6]
		analog_en |-> power_ctrl.anti_alias_filter == pwr1_reg[7:6])
		else $error("anti-alias power code wrong");

	a_enc_power: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ9]
		analog_en |-> power_ctrl.encode_converter == pwr1_reg[3:2])
		else $error("encode converter power code wrong");

	a_dec_power: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ10]
		analog_en |-> power_ctrl.decode_converter == pwr1_reg[1:0])
		else $error("decode converter power code wrong");

	a_mic_amp_power: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ11]
		analog_en |-> power_ctrl.mic_amp == pwr2_reg[7:6])
		else $error("mic amplifier power code wrong");

	a_gain_amp_power: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ12]
		analog_en |-> power_ctrl.gain_amp == pwr2_reg[5:4])
		else $error("input gain amplifier power code wrong");

	a_vol_amp_power: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ13]
		analog_en |-> power_ctrl.volume_amp == pwr2_reg[3:2])
		else $error("volume amplifier power code wrong");

	a_image_gate: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ15]
		!analog_en |-> power_ctrl.anti_image_filter == 2'h0)
		else $error("anti-image power not forced off");

	a_enc_gate: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ15]
		!analog_en |-> power_ctrl.encode_converter == 2'h0)
		else $error("encode converter power not forced off");

	a_dec_gate: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ15]
		!analog_en |-> power_ctrl.decode_converter == 2'h0)
		else $error("decode converter power not forced off");

	a_mic_gate: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ15]
		!analog_en |-> power_ctrl.mic_amp == 2'h0)
		else $error("mic amplifier power not forced off");

	a_gain_gate: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ15]
		!analog_en |-> power_ctrl.gain_amp == 2'h0)
		else $error("input gain amplifier power not forced off");

	a_bandgap_on: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ15]
		power_ctrl.bandgap_on == pwr2_reg[0])
		else $error("bandgap state wrong");

	a_enable_off: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ15]
		(wr_pwr2 && !wr_data[0]) |=> !power_ctrl.bandgap_on)
		else $error("bandgap on after master disable");

	a_enable_on: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ15]
		(wr_pwr2 && wr_data[0]) |=> power_ctrl.bandgap_on)
		else $error("bandgap off after master enable");

	a_crystal_ungated: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ14]
		power_ctrl.crystal_oscillator_pd == pwr2_reg[1])
		else $error("crystal power-down follows wrong bit");

	// ************************************************************
	// gain field checks
	// ************************************************************
	a_mic_code_load: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ4]
		wr_mic |=> gain_ctrl.mic_gain_code == $past(wr_data[7:3]))
		else $error("mic gain code not loaded");

	a_mic_off_zero: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ4]
		gain_ctrl.mic_gain_off == (gain_ctrl.mic_gain_code == 5'h00))
		else $error("mic off does not match zero code");

	a_volume_mute_wr: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ1]
		(wr_vol && wr_data[7:3] == 5'h00) |=> gain_ctrl.volume_mute)
		else $error("volume not muted at code zero");

	a_sidetone_on: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ3]
		(vol_st_reg[0] && power_ctrl.anti_image_filter != 2'h0) |-> gain_ctrl.sidetone_on)
		else $error("sidetone off while enabled");

	a_sidetone_en_wr: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ3]
		(wr_vol && !wr_data[0]) |=> !gain_ctrl.sidetone_on)
		else $error("sidetone on after disable write");

	a_image_sidetone: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ8]
		power_ctrl.anti_image_filter == 2'h0 |-> !gain_ctrl.sidetone_on)
		else $error("sidetone on with its amplifier unpowered");

	a_st_gain_raw: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ2]
		gain_ctrl.sidetone_gain == sidetone_gain_e'(vol_st_reg[2:1]))
		else $error("sidetone gain does not follow field");

	// ************************************************************
	// load, hold, reset and reserved-bit checks
	// ************************************************************
	a_pwr1_load: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ17]
		wr_pwr1 |=> pwr1_reg == $past(wr_data))
		else $error("first power register not loaded");

	a_pwr2_load: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ17]
		wr_pwr2 |=> pwr2_reg == $past(wr_data))
		else $error("second power register not loaded");

	a_mode_load: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ17]
		wr_mode |=> codec_mode == $past(wr_data[MODE_BITS-1:0]))
		else $error("codec mode not loaded");

	a_vol_hold: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ17]
		!(wr_vol || general_reset) |=> $stable(vol_st_reg))
		else $error("volume register changed without write");

	a_mic_hold: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ17]
		!(wr_mic || general_reset) |=> $stable(mic_gain_reg))
		else $error("mic gain register changed without write");

	a_pwr2_hold: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ17]
		!(wr_pwr2 || general_reset) |=> $stable(pwr2_reg))
		else $error("second power register changed without write");

	a_mode_hold: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ17]
		!(wr_mode || general_reset) |=> $stable(mode_reg))
		else $error("mode register changed without write");

	a_ignored_addr: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ17]
		(wr_valid && !wr_known) |=> $stable({vol_st_reg, mic_gain_reg, pwr1_reg, pwr2_reg, mode_reg}))
		else $error("unknown address changed a register");

	a_reset_rest: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ16]
		general_reset |=> (mic_gain_reg == 8'h00 && pwr1_reg == 8'h00 && mode_reg == 8'h00))
		else $error("general reset left a register set");

	a_reserved_mic: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ5]
		(wr_mic && wr_data[2:0] != 3'h0) |=> reserved_written)
		else $error("reserved gain bits not flagged");

	a_reserved_mode: assert property (@(posedge clk_sys) disable iff (!resetn) // [RQ5]
		(wr_mode && wr_data[7:3] != 5'h00) |=> reserved_written)
		else $error("reserved mode bits not flagged");
endmodule
`default_nettype wire

// *** dv/test_audio_gain_power_regs.sv ***
// self-checking bench for the gain and power register bank
`timescale 1ns/1ps
`default_nettype none
module test_audio_gain_power_regs
	import agp_pkg::*;
;
	logic        clk_sys;
	logic        resetn;
	logic        wr_valid;
	logic [7:0]  wr_addr;
	logic [7:0]  wr_data;
	gain_ctrl_s  gain_ctrl;
	power_ctrl_s power_ctrl;
	logic [2:0]  codec_mode;
	logic        reserved_written;
	int          fails;
	int          n_compared;
	int          cycles;
	int          seed;
	int          i;
	logic [7:0]  m [5];
	logic [7:0]  addrs [8];

	audio_gain_power_regs #(.MODE_BITS(3)) dut (
		.clk_sys          (clk_sys),
		.resetn           (resetn),
		.wr_valid         (wr_valid),
		.wr_addr          (wr_addr),
		.wr_data          (wr_data),
		.gain_ctrl        (gain_ctrl),
		.power_ctrl       (power_ctrl),
		.codec_mode       (codec_mode),
		.reserved_written (reserved_written)
	);

	// ************************************************************
	// reporting
	// ************************************************************
	task automatic report(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_gain(input gain_ctrl_s exp);
		report(32'(gain_ctrl), 32'(exp));
	endtask
	task automatic cmp_power(input power_ctrl_s exp);
		report(32'(power_ctrl), 32'(exp));
	endtask
	task automatic cmp_mode(input logic [3:0] exp);
		report(32'({codec_mode, reserved_written}), 32'(exp));
	endtask
	task automatic stop_test();
		if (fails == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ************************************************************
	// reference model
	// ************************************************************
	task automatic check_all();
		gain_ctrl_s  eg;
		power_ctrl_s ep;
		logic [1:0]  en;
		en = {2{m[3][0]}};
		ep = {m[2][7:6] & en, m[2][5:4] & en, m[2][3:2] & en, m[2][1:0] & en,
			m[3][7:6] & en, m[3][5:4] & en, m[3][3:2] & en, m[3][0], m[3][1]};
		eg.volume_code = m[0][7:3];
		eg.volume_mute = (m[0][7:3] == 5'h00);
		eg.sidetone_gain = sidetone_gain_e'(m[0][2:1]);
		eg.sidetone_on = m[0][0] & (ep.anti_image_filter != 2'h0);
		eg.mic_gain_code = m[1][7:3];
		eg.mic_gain_off = (m[1][7:3] == 5'h00);
		cmp_gain(eg);
		cmp_power(ep);
		cmp_mode({m[4][2:0], (m[1][2:0] != 3'h0) || (m[4][7:3] != 5'h00)});
	endtask
	task automatic model_write(input logic [7:0] a, input logic [7:0] d);
		case (a)
			8'h01: m = '{default: 8'h00};
			8'h62: m[0] = d;
			8'h63: m[1] = d;
			8'h64: m[2] = d;
			8'h65: m[3] = d;
			8'h70: m[4] = d;
			default: ;
		endcase
	endtask
	// one cycle: compare, then present the next write
	task automatic step(input logic v, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		check_all();
		wr_valid = v;
		wr_addr = a;
		wr_data = d;
		if (v && resetn) model_write(a, d);
	endtask

	// ************************************************************
	// clock, timeout and stimulus
	// ************************************************************
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles >= 3000) begin
			fails++;
			stop_test();
		end
	end
	initial begin
		resetn = 1'b0;
		wr_valid = 1'b0;
		wr_addr = 8'h00;
		wr_data = 8'h00;
		seed = 32'h43b1;
		m = '{default: 8'h00};
		addrs = '{8'h01, 8'h62, 8'h63, 8'h64, 8'h65, 8'h70, 8'h66, 8'h00};
		for (i = 0; i < 7; i++) step(1'(i < 6), 8'h62, 8'hFF);
		resetn = 1'b1;
		step(1'b1, 8'h65, 8'h0D);
		for (i = 0; i < 32; i++) begin
			step(1'b1, 8'h62, 8'(i * 8 + i % 8));
			step(1'b1, 8'h63, 8'(i * 8));
		end
		for (i = 0; i < 256; i++) begin
			step(1'b1, 8'h64, 8'(i));
			step(1'b1, 8'h65, 8'(255 - i));
		end
		step(1'b1, 8'h01, 8'h5A);
		step(1'b1, 8'h71, 8'hFF);
		for (i = 0; i < 600; i++) begin
			addrs[7] = 8'($random(seed));
			step(1'($random(seed)), addrs[($random(seed) & 32'h7FFF) % 8], 8'($random(seed)));
		end
		@(negedge clk_sys);
		resetn = 1'b0;
		wr_valid = 1'b0;
		m = '{default: 8'h00};
		#1;
		check_all();
		step(1'b0, 8'h00, 8'h00);
		resetn = 1'b1;
		for (i = 0; i < 20; i++) step(1'b1, addrs[i % 7], 8'($random(seed)));
		step(1'b0, 8'h00, 8'h00);
		stop_test();
	end
endmodule
`default_nettype wire
